// ===== ccpd_pkg.sv
// Constants for the comparator conditioning and pulse delay block
// Operation
// (R1) Pulse output delayed 0..15 system clocks; code zero passes straight through.
// (R2) Comparator 4 low for selected cycles raises its interrupt when enabled.
// (R3) Duration code n selects a low-time threshold of 2**n cycles.
// (R4) Edge select bit: 0 picks falling, 1 picks rising comparator 1 edge.
// (R5) Six-bit debounce field sets comparator 1 glitch window in clocks.
// (R6) Two toggles within the window are bounce; filtered value is kept.
// (R7) Per comparator, trim source side: 0 negative input, 1 positive input.
// (R8) Each comparator has its own five-bit offset code in trim register.
// (R9) Comparator 2 reference chosen by five-bit code in low bits.
// (R10) Comparators 3 and 4 take four-bit reference codes in low nibble.
// (R11) Trigger enable lets the selected comparator 1 edge start a pulse.
// (R12) Each comparator has a readable trim-mode bit enabling offset trim.
// (R13) Software reads each comparator output state as read-only status.
// (R14) Eight-bit toggle counter, cleared by single-pulse strobe, saturates at 255.
// (R15) Comparator outputs synchronised first; disabled comparator yields no events.
package ccpd_pkg;
    localparam logic [7:0] ADDR_ENA_HYS   = 8'h15;
    localparam logic [7:0] ADDR_TRIM_A    = 8'h16;
    localparam logic [7:0] ADDR_TRIM_B    = 8'h17;
    localparam logic [7:0] ADDR_TRIM_C    = 8'h18;
    localparam logic [7:0] ADDR_TRIM_D    = 8'h19;
    localparam logic [7:0] ADDR_DLY_CREF  = 8'h1A;
    localparam logic [7:0] ADDR_B_REF     = 8'h1B;
    localparam logic [7:0] ADDR_D_CTL     = 8'h1C;
    localparam logic [7:0] ADDR_A_CTL     = 8'h1D;
    localparam logic [7:0] ADDR_MISC_CTL  = 8'h20;
    localparam logic [7:0] ADDR_STATUS    = 8'h21;
    localparam logic [7:0] ADDR_TOGGLE    = 8'h22;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h23;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h24;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h25;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam int         SIDE_BIT       = 7;
    localparam int         EDGE_BIT       = 6;
    localparam int         DLY_LSB        = 4;
    localparam int         DUR_LSB        = 5;
    localparam int         MISC_PTEN_BIT  = 4;
    localparam int         MISC_STB_BIT   = 5;
    localparam int         IRQ_A_EDGE     = 0;
    localparam int         IRQ_D_LOW      = 1;
    localparam logic [7:0] TOGGLE_MAX     = 8'hFF;
endpackage

// ===== ccpd_sync.sv
// Two-flop synchroniser for one comparator output
`timescale 1ns/1ps
`default_nettype none
module ccpd_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    // Two stages before any logic looks at the level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== ccpd_delay.sv
// Programmable pulse delay line of 0 to DEPTH clocks
`timescale 1ns/1ps
`default_nettype none
module ccpd_delay #(
    parameter int DEPTH = 15,
    parameter int SW    = 4
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          d,
    input  wire logic [SW-1:0] sel,
    output logic               q
);
    logic [DEPTH:1] tap_q;

    // Refuse a depth that the select code cannot reach
    if (DEPTH < 1 || DEPTH >= (1 << SW)) begin : g_bad_depth
        $error("ccpd_delay: bad DEPTH");
    end

    // Shift chain, one stage per clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tap_q <= '0;
        end else begin
            tap_q <= {tap_q[DEPTH-1:1], d};
        end
    end

    // (R1) tap select, zero is direct
    always_comb begin
        if (sel == '0) begin
            q = d;
        end else begin
            q = tap_q[sel];
        end
    end
endmodule
`default_nettype wire

// ===== ccpd_top.sv
// Comparator conditioning, pulse trigger and delay top level
`timescale 1ns/1ps
`default_nettype none
module ccpd_top
    import ccpd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic [3:0] comp_out_raw,
    input  wire logic       pulse_gen_in,
    output logic            pulse_out,
    output logic            pulse_trigger,
    output logic [3:0]      comp_enable,
    output logic [3:0]      comp_hysteresis,
    output logic [3:0]      trim_mode_enable,
    output logic [3:0]      trim_source_side_sel,
    output logic [19:0]     offset_adjust_code,
    output logic [4:0]      comp_b_ref_select,
    output logic [3:0]      comp_c_ref_select,
    output logic [3:0]      comp_d_ref_select,
    output logic            irq
);
    logic [7:0] ena_hys_q;
    logic [7:0] trim_q [4];
    logic [7:0] dly_cref_q;
    logic [7:0] b_ref_q;
    logic [7:0] d_ctl_q;
    logic [7:0] a_ctl_q;
    logic [7:0] misc_q;
    logic [7:0] toggle_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_en_q;
    logic [3:0] comp_sync;
    logic [3:0] comp_live;
    logic       a_filt_q;
    logic       a_filt_prev_q;
    logic       a_raw_prev_q;
    logic [5:0] win_cnt_q;
    logic       win_open_q;
    logic [7:0] low_cnt_q;
    logic       low_hit_q;
    logic       stb_prev_q;
    logic       wr_stb;
    logic       rd_stb;
    logic       a_edge;
    logic       a_toggle;
    logic       d_low_event;
    logic [7:0] dur_limit;
    logic [2:0] dur_code;

    // Bus access strobes; answer one cycle after the request
    assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    // Control register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ena_hys_q  <= REG_RESET;
            trim_q[0]  <= REG_RESET;
            trim_q[1]  <= REG_RESET;
            trim_q[2]  <= REG_RESET;
            trim_q[3]  <= REG_RESET;
            dly_cref_q <= REG_RESET;
            b_ref_q    <= REG_RESET;
            d_ctl_q    <= REG_RESET;
            a_ctl_q    <= REG_RESET;
            misc_q     <= REG_RESET;
            irq_en_q   <= 2'h0;
        end else if (wr_stb) begin
            case (wb_adr_i)
                ADDR_ENA_HYS:  ena_hys_q  <= wb_dat_i[7:0];
                ADDR_TRIM_A:   trim_q[0]  <= wb_dat_i[7:0];
                ADDR_TRIM_B:   trim_q[1]  <= wb_dat_i[7:0];
                ADDR_TRIM_C:   trim_q[2]  <= wb_dat_i[7:0];
                ADDR_TRIM_D:   trim_q[3]  <= wb_dat_i[7:0];
                ADDR_DLY_CREF: dly_cref_q <= wb_dat_i[7:0];
                ADDR_B_REF:    b_ref_q    <= wb_dat_i[7:0];
                ADDR_D_CTL:    d_ctl_q    <= wb_dat_i[7:0];
                ADDR_A_CTL:    a_ctl_q    <= wb_dat_i[7:0];
                ADDR_MISC_CTL: misc_q     <= wb_dat_i[7:0];
                ADDR_IRQ_EN:   irq_en_q   <= wb_dat_i[1:0];
                default:       ;
            endcase
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_stb) begin
            case (wb_adr_i)
                ADDR_ENA_HYS:  wb_dat_o <= {24'h0, ena_hys_q};
                ADDR_TRIM_A:   wb_dat_o <= {24'h0, trim_q[0]};
                ADDR_TRIM_B:   wb_dat_o <= {24'h0, trim_q[1]};
                ADDR_TRIM_C:   wb_dat_o <= {24'h0, trim_q[2]};
                ADDR_TRIM_D:   wb_dat_o <= {24'h0, trim_q[3]};
                ADDR_DLY_CREF: wb_dat_o <= {24'h0, dly_cref_q};
                ADDR_B_REF:    wb_dat_o <= {24'h0, b_ref_q};
                ADDR_D_CTL:    wb_dat_o <= {24'h0, d_ctl_q};
                ADDR_A_CTL:    wb_dat_o <= {24'h0, a_ctl_q};
                ADDR_MISC_CTL: wb_dat_o <= {24'h0, misc_q};
                // (R13) live comparator states
                ADDR_STATUS:   wb_dat_o <= {24'h0, comp_live, 3'h0, a_filt_q};
                // (R14) toggle count readback
                ADDR_TOGGLE:   wb_dat_o <= {24'h0, toggle_q};
                ADDR_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat_q};
                ADDR_IRQ_EN:   wb_dat_o <= {30'h0, irq_en_q};
                default:       wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // (R15) synchronise every comparator output
    for (genvar i = 0; i < 4; i++) begin : g_sync
        ccpd_sync u_sync (
            .clk (clk),
            .rst (rst),
            .d   (comp_out_raw[i]),
            .q   (comp_sync[i])
        );
    end

    // (R15) disabled comparators held low
    assign comp_enable = ena_hys_q[7:4];
    assign comp_live   = comp_sync & {comp_enable[0], comp_enable[1],
                                      comp_enable[2], comp_enable[3]};
    assign comp_hysteresis = ena_hys_q[3:0];

    // (R12) trim mode bits, comparator 1 in bit 3
    assign trim_mode_enable = misc_q[3:0];

    // (R7) (R8) trim side and offset codes
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            trim_source_side_sel[k]   = trim_q[k][SIDE_BIT];
            offset_adjust_code[5*k+:5] = trim_q[k][4:0];
        end
    end

    // (R9) comparator 2 reference
    assign comp_b_ref_select = b_ref_q[4:0];
    // (R10) comparators 3 and 4 references
    assign comp_c_ref_select = dly_cref_q[3:0];
    assign comp_d_ref_select = d_ctl_q[3:0];

    // (R5) (R6) debounce window on comparator 1
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_raw_prev_q <= 1'b0;
            a_filt_q     <= 1'b0;
            win_cnt_q    <= 6'h00;
            win_open_q   <= 1'b0;
        end else begin
            a_raw_prev_q <= comp_live[3];
            if (win_open_q) begin
                if (comp_live[3] != a_raw_prev_q) begin
                    win_open_q <= 1'b0;
                end else if (win_cnt_q <= 6'h01) begin
                    win_open_q <= 1'b0;
                    a_filt_q   <= comp_live[3];
                end else begin
                    win_cnt_q <= win_cnt_q - 6'h01;
                end
            end else if (comp_live[3] != a_filt_q) begin
                if (a_ctl_q[5:0] == 6'h00) begin
                    a_filt_q <= comp_live[3];
                end else begin
                    win_open_q <= 1'b1;
                    win_cnt_q  <= a_ctl_q[5:0];
                end
            end
        end
    end

    // (R4) edge select on filtered output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_filt_prev_q <= 1'b0;
        end else begin
            a_filt_prev_q <= a_filt_q;
        end
    end
    assign a_toggle = a_filt_q ^ a_filt_prev_q;
    assign a_edge   = a_toggle & (a_filt_q == a_ctl_q[EDGE_BIT]);

    // (R11) trigger pulse on selected edge
    assign pulse_trigger = a_edge & misc_q[MISC_PTEN_BIT];

    // (R14) toggle counter with strobe clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stb_prev_q <= 1'b0;
            toggle_q   <= 8'h00;
        end else begin
            stb_prev_q <= misc_q[MISC_STB_BIT];
            if (misc_q[MISC_STB_BIT] & ~stb_prev_q) begin
                toggle_q <= 8'h00;
            end else if (a_toggle && toggle_q != TOGGLE_MAX) begin
                toggle_q <= toggle_q + 8'h01;
            end
        end
    end

    // (R3) threshold is 2**code cycles
    assign dur_code  = d_ctl_q[DUR_LSB+:3];
    assign dur_limit = 8'h01 << dur_code;

    // (R2) low-duration detector on comparator 4
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_q <= 8'h00;
            low_hit_q <= 1'b0;
        end else if (!comp_enable[3] || comp_live[0]) begin
            low_cnt_q <= 8'h00;
            low_hit_q <= 1'b0;
        end else if (!low_hit_q) begin
            if (low_cnt_q + 8'h01 >= dur_limit) begin
                low_hit_q <= 1'b1;
            end
            low_cnt_q <= low_cnt_q + 8'h01;
        end
    end
    assign d_low_event = comp_enable[3] & ~comp_live[0] & ~low_hit_q
                       & (low_cnt_q + 8'h01 >= dur_limit);

    // Sticky status; set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= 2'h0;
        end else begin
            if (wr_stb && wb_adr_i == ADDR_IRQ_CLR) begin
                irq_stat_q <= irq_stat_q & ~wb_dat_i[1:0]
                              | {d_low_event, a_edge};
            end else begin
                irq_stat_q <= irq_stat_q | {d_low_event, a_edge};
            end
        end
    end
    assign irq = |(irq_stat_q & irq_en_q);

    // (R1) pulse output delay
    ccpd_delay #(
        .DEPTH (15),
        .SW    (4)
    ) u_delay (
        .clk (clk),
        .rst (rst),
        .d   (pulse_gen_in),
        .sel (dly_cref_q[DLY_LSB+:4]),
        .q   (pulse_out)
    );
endmodule
`default_nettype wire

// ===== ccpd_top_assertions.sv
// Concurrent checks on the comparator conditioning block ports
`timescale 1ns/1ps
`default_nettype none
module ccpd_top_chk (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ack_o,
    input  wire logic [3:0]  comp_out_raw,
    input  wire logic        pulse_gen_in,
    input  wire logic        pulse_out,
    input  wire logic        pulse_trigger,
    input  wire logic [4:0]  comp_b_ref_select
);
    logic [3:0]  dly_q;
    logic        pten_q;
    logic [15:0] hist_q;
    logic [3:0]  raw_q;
    logic [6:0]  quiet_q;
    logic        wr;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Write taken at this edge
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    // Shadow of delay code and trigger enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dly_q  <= 4'h0;
            pten_q <= 1'b0;
        end else if (wr && wb_adr_i == 8'h1A) begin
            dly_q <= wb_dat_i[7:4];
        end else if (wr && wb_adr_i == 8'h20) begin
            pten_q <= wb_dat_i[4];
        end
    end
    // Pulse history and comparator quiet time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hist_q  <= 16'h0000;
            raw_q   <= 4'h0;
            quiet_q <= 7'h00;
        end else begin
            hist_q  <= {hist_q[14:0], pulse_gen_in};
            raw_q   <= comp_out_raw;
            quiet_q <= (comp_out_raw != raw_q) ? 7'h00 : quiet_q + 7'(quiet_q != 7'h7F);
        end
    end
    // Bus answer, delay line and trigger behaviour
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    delay_zero_a: assert property (dly_q == 4'h0 |-> pulse_out == pulse_gen_in)
        else $error("code zero does not pass pulse through");
    delay_tap_a: assert property (dly_q != 4'h0 && dly_q == $past(dly_q, 2)
        |-> pulse_out == hist_q[dly_q - 4'h1])
        else $error("pulse delay differs from code");
    trig_gated_a: assert property (!pten_q && !$past(pten_q) |-> !pulse_trigger)
        else $error("trigger while disabled");
    trig_single_a: assert property (pulse_trigger |=> !pulse_trigger)
        else $error("trigger longer than one cycle");
    trig_quiet_a: assert property (quiet_q > 7'd100 |-> !pulse_trigger)
        else $error("trigger without comparator change");
    bref_map_a: assert property (wr && wb_adr_i == 8'h1B
        |=> comp_b_ref_select == $past(wb_dat_i[4:0]))
        else $error("reference select not written");
endmodule
bind ccpd_top ccpd_top_chk chk_u (.*);
`default_nettype wire

// ===== ccpd_partner.sv
// Behavioural comparators and pulse generator beside the block
`timescale 1ns/1ps
`default_nettype none
module ccpd_partner (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  level,
    input  wire logic  manual_pulse,
    input  wire logic  pulse_trigger,
    output logic [3:0] comp_out_raw,
    output logic       pulse_gen_in
);
    logic [1:0] width_q;
    // All comparators follow the analog level
    always_ff @(posedge clk) begin
        comp_out_raw <= {4{level}};
    end
    // Triggered pulses last three clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            width_q <= 2'h0;
        end else if (pulse_trigger) begin
            width_q <= 2'h3;
        end else if (width_q != 2'h0) begin
            width_q <= width_q - 2'h1;
        end
    end
    // Software pulses merged with triggered ones
    assign pulse_gen_in = manual_pulse | (width_q != 2'h0);
endmodule
`default_nettype wire

// ===== ccpd_top_tb_top.sv
// Self-checking testbench for the comparator conditioning block
`timescale 1ns/1ps
`default_nettype none
module ccpd_top_tb_top
    import ccpd_pkg::*;
;
    logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, level;
    logic        pulse_gen_in, pulse_out, pulse_trigger, manual_pulse;
    logic [3:0]  wb_sel_i, comp_out_raw, comp_enable, comp_hysteresis, trim_mode_enable;
    logic [3:0]  trim_source_side_sel, comp_c_ref_select, comp_d_ref_select;
    logic [4:0]  comp_b_ref_select;
    logic [19:0] offset_adjust_code;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0]  wb_adr_i, rd, rv [21:29];
    logic [7:0]  mk [21:29] = '{8'hFF, 8'h9F, 8'h9F, 8'h9F, 8'h9F, 8'hFF, 8'h1F, 8'hEF, 8'h7F};
    logic [3:0]  dl [4] = '{4'h0, 4'h1, 4'h7, 4'hF};
    int          n_errors, num_checks, n_trig, seed, n, m;

    ccpd_top dut_u (.*);
    ccpd_partner model_u (.*);

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Count trigger pulses
    always @(posedge clk) n_trig <= n_trig + int'(pulse_trigger === 1'b1);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic results;
        $display("mismatches %0d comparisons %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Classic single bus cycle, waits for ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 24'h000000, d};
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk);
        if (k >= 20) begin
            n_errors++;
            results();
        end
    endtask
    task automatic hold(input logic v, input int k);
        level <= v;
        repeat (k) @(posedge clk);
    endtask

    initial begin
        {n_errors, num_checks, n_trig} = '0;
        seed = 32'h66616EF2;
        {wb_cyc_i, wb_stb_i, wb_we_i, level, manual_pulse, wb_adr_i} = '0;
        {wb_sel_i, wb_dat_i} = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wb_sel_i <= 4'hF;
        @(posedge clk);
        chk({irq, comp_enable, offset_adjust_code}, 32'h0);
        for (int a = 21; a < 30; a++) begin
            rv[a] = 8'($random(seed)) & mk[a];
            wb(1'b1, 8'(a), rv[a]);
            wb(1'b0, 8'(a), 8'h00);
            chk(rd, rv[a]);
        end
        chk(comp_b_ref_select, rv[27][4:0]);
        chk({comp_enable, comp_hysteresis}, rv[21]);
        chk({comp_c_ref_select, comp_d_ref_select}, {rv[26][3:0], rv[28][3:0]});
        for (int k = 0; k < 4; k++) begin
            chk(offset_adjust_code[5*k+:5], rv[22+k][4:0]);
            chk(trim_source_side_sel[k], rv[22+k][7]);
        end
        wb(1'b1, ADDR_MISC_CTL, 8'h0A);
        chk(trim_mode_enable, 4'hA);
        wb(1'b0, ADDR_MISC_CTL, 8'h00);
        chk(rd, 8'h0A);
        wb_sel_i <= 4'hE;
        wb(1'b1, ADDR_B_REF, 8'h00);
        wb_sel_i <= 4'hF;
        chk(comp_b_ref_select, rv[27][4:0]);
        wb(1'b0, 8'h30, 8'h00);
        chk(rd, 8'h00);
        $display("register test done");
        foreach (dl[i]) begin
            wb(1'b1, ADDR_DLY_CREF, {dl[i], 4'h0});
            manual_pulse <= 1'b1;
            n = 0;
            #1;
            while (pulse_out !== 1'b1 && n < 40) begin
                @(posedge clk);
                manual_pulse <= 1'b0;
                n++;
                #1;
            end
            @(posedge clk);
            manual_pulse <= 1'b0;
            chk(n, dl[i]);
            repeat (20) @(posedge clk);
        end
        $display("delay test done");
        wb(1'b1, ADDR_ENA_HYS, 8'hF0);
        for (int e = 0; e < 3; e++) begin
            wb(1'b1, ADDR_A_CTL, (e == 1) ? 8'h00 : 8'h40);
            wb(1'b1, ADDR_MISC_CTL, (e == 2) ? 8'h00 : 8'h10);
            m = n_trig;
            repeat (3) begin
                hold(1'b1, 12);
                hold(1'b0, 12);
            end
            chk(n_trig - m, (e == 2) ? 0 : 3);
        end
        wb(1'b1, ADDR_MISC_CTL, 8'h30);
        repeat (5) hold(!level, 8);
        wb(1'b0, ADDR_TOGGLE, 8'h00);
        chk(rd, 8'h05);
        repeat (260) hold(!level, 6);
        wb(1'b0, ADDR_TOGGLE, 8'h00);
        chk(rd, TOGGLE_MAX);
        wb(1'b1, ADDR_MISC_CTL, 8'h10);
        wb(1'b1, ADDR_MISC_CTL, 8'h30);
        wb(1'b0, ADDR_TOGGLE, 8'h00);
        chk(rd, 8'h00);
        wb(1'b1, ADDR_A_CTL, 8'h54);
        hold(1'b0, 40);
        m = n_trig;
        repeat (4) begin
            hold(1'b1, 1 + $unsigned($random(seed)) % 15);
            hold(1'b0, 40);
        end
        hold(1'b1, 10);
        chk(n_trig - m, 0);
        hold(1'b1, 30);
        chk(n_trig - m, 1);
        $display("edge test done");
        wb(1'b1, ADDR_IRQ_EN, 8'h02);
        for (int c = 0; c < 8; c++) begin
            hold(1'b1, 10);
            wb(1'b1, ADDR_D_CTL, {c[2:0], 5'h00});
            wb(1'b1, ADDR_IRQ_CLR, 8'h03);
            chk(irq, 1'b0);
            if (c > 1) begin
                hold(1'b0, (1 << c) / 2);
                hold(1'b1, 6);
                chk(irq, 1'b0);
            end
            hold(1'b0, (1 << c) + 6);
            chk(irq, 1'b1);
        end
        wb(1'b1, ADDR_IRQ_EN, 8'h00);
        chk(irq, 1'b0);
        wb(1'b0, ADDR_IRQ_STAT, 8'h00);
        chk(rd[1], 1'b1);
        $display("interrupt test done");
        hold(1'b1, 8);
        wb(1'b0, ADDR_STATUS, 8'h00);
        chk(rd[7:4], 4'hF);
        wb(1'b1, ADDR_ENA_HYS, 8'h00);
        m = n_trig;
        hold(1'b0, 40);
        hold(1'b1, 40);
        wb(1'b0, ADDR_STATUS, 8'h00);
        chk(rd[7:4], 4'h0);
        chk(n_trig - m, 0);
        $display("status test done");
        results();
    end
endmodule
`default_nettype wire
